// ===== hdl/pcxb_pin_mux.sv
// priority crossbar pin multiplexer with port mode registers
//
// Operation
// - smbus data and clock pins allocated together
// - uart fixed on pins 4 and 5
// - leftover pins act as plain port I/O
// - slave select gets pin only in four-wire
// - smbus line order follows its swap bit
// - analog pin: no weak pullup, driver, receiver
// - input mode 1 digital, resets digital
// - driver type comes from output mode bit
// - smbus pins always open-drain
// - weak pullup on undriven open-drain pins
// - crossbar off: inputs, selects ignored
// - crossbar off: all drivers off
// - select bit 7 drives strong pullups
// - select bit 6 routes second smbus
// - select bit 5 routes async comparator
// - select bit 4 routes comparator
// - select bit 3 routes system clock
// - select bit 2 routes first smbus
// - select bit 1 routes spi
// - select bit 0 routes uart
// - each peripheral but uart takes lowest free pin
// - skipped pins passed over as taken
`timescale 1ns/1ns
module pcxb_pin_mux
    import pcxb_pkg::*;
#(
    parameter int PINS      = 21,
    parameter int XBAR_PINS = 20
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // register port
    input  wire logic [7:0]            regAddr,
    input  wire logic [7:0]            regWdata,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic      [7:0]            regRdata,
    // peripheral side
    input  wire logic [SLOT_COUNT-1:0] periphOut,
    input  wire logic [SLOT_COUNT-1:0] periphOe,
    output logic      [SLOT_COUNT-1:0] periphIn,
    input  wire logic [1:0]            smbusPinSwap,
    input  wire logic [1:0]            spiSlaveSelectMode,
    // pad side
    input  wire logic [PINS-1:0]       padIn,
    output logic      [PINS-1:0]       padOut,
    output logic      [PINS-1:0]       padOe,
    output logic      [PINS-1:0]       weakPullup,
    output logic      [PINS-1:0]       rxEnable,
    output logic      [1:0]            strongPullup
);
    localparam int PIN_W = $clog2(PINS);

    logic [7:0]       selFirst;
    logic [7:0]       selSecond;
    logic [7:0]       inMode  [PORT_COUNT];
    logic [7:0]       outMode [PORT_COUNT];
    logic [7:0]       skip    [PORT_COUNT];
    logic [7:0]       latch   [PORT_COUNT];
    logic [23:0]      inModeF;
    logic [23:0]      outModeF;
    logic [23:0]      skipF;
    logic [23:0]      latchF;
    logic [PINS-1:0]  padSyncA;
    logic [PINS-1:0]  padSync;
    logic             xbarEn;
    logic [SLOT_COUNT-1:0] slotReq;
    logic [PINS-1:0]  nextOwned;
    logic [SLOT_W-1:0] nextPinSlot [PINS];
    logic [SLOT_COUNT-1:0] nextSlotHas;
    logic [PIN_W-1:0] nextSlotPin [SLOT_COUNT];
    logic [PINS-1:0]  pinOwned;
    logic [PINS-1:0]  smbPin;
    logic [SLOT_COUNT-1:0] slotHas;
    logic [PIN_W-1:0] slotPin [SLOT_COUNT];
    logic [PINS-1:0]  next_padOut;
    logic [PINS-1:0]  next_padOe;
    logic [PINS-1:0]  next_weakPullup;
    logic [PINS-1:0]  next_smbPin;

    // true when addr falls inside a per-port register group
    function automatic logic inGroup(input logic [7:0] addr,
                                     input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        return d < 8'(PORT_COUNT);
    endfunction : inGroup

    function automatic int groupIdx(input logic [7:0] addr,
                                    input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        return int'(d[1:0]);
    endfunction : groupIdx

    function automatic logic isSmb(input int s);
        return s >= SLOT_SMB0_SDA && s <= SLOT_SMB1_SCL;
    endfunction : isSmb

    // allocation step to slot, swapping each smbus pair on request
    function automatic int stepSlot(input int st, input logic [1:0] sw);
        int s;
        s = st;
        if (sw[0] && st == SLOT_SMB0_SDA) s = SLOT_SMB0_SCL;
        if (sw[0] && st == SLOT_SMB0_SCL) s = SLOT_SMB0_SDA;
        if (sw[1] && st == SLOT_SMB1_SDA) s = SLOT_SMB1_SCL;
        if (sw[1] && st == SLOT_SMB1_SCL) s = SLOT_SMB1_SDA;
        return s;
    endfunction : stepSlot

    // register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            selFirst  <= SEL_FIRST_RST;
            selSecond <= SEL_SECOND_RST;
        end else if (regWrite && regAddr == ADDR_SEL_FIRST) begin
            selFirst  <= regWdata;
        end else if (regWrite && regAddr == ADDR_SEL_SECOND) begin
            selSecond <= regWdata & SS_RW_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PORT_COUNT; i++) begin
                inMode[i]  <= INMODE_RST;
                outMode[i] <= OUTMODE_RST;
                skip[i]    <= SKIP_RST;
                latch[i]   <= LATCH_RST;
            end
        end else if (regWrite) begin
            if (inGroup(regAddr, ADDR_INMODE0))
                inMode[groupIdx(regAddr, ADDR_INMODE0)] <= regWdata;
            if (inGroup(regAddr, ADDR_OUTMODE0))
                outMode[groupIdx(regAddr, ADDR_OUTMODE0)] <= regWdata;
            if (inGroup(regAddr, ADDR_SKIP0))
                skip[groupIdx(regAddr, ADDR_SKIP0)] <= regWdata;
            if (inGroup(regAddr, ADDR_LATCH0))
                latch[groupIdx(regAddr, ADDR_LATCH0)] <= regWdata;
        end
    end

    assign inModeF  = {inMode[2], inMode[1], inMode[0]};
    assign outModeF = {outMode[2], outMode[1], outMode[0]};
    assign skipF    = {skip[2], skip[1], skip[0]};
    assign latchF   = {latch[2], latch[1], latch[0]};
    assign xbarEn   = selSecond[SS_XBAR_EN];

    // pad input synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            padSyncA <= '0;
            padSync  <= '0;
        end else begin
            padSyncA <= padIn;
            padSync  <= padSyncA;
        end
    end

    // register reads, data valid the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= 8'h00;
            if (regAddr == ADDR_SEL_FIRST)
                regRdata <= selFirst;
            else if (regAddr == ADDR_SEL_SECOND)
                regRdata <= selSecond;
            else if (inGroup(regAddr, ADDR_INMODE0))
                regRdata <= inMode[groupIdx(regAddr, ADDR_INMODE0)];
            else if (inGroup(regAddr, ADDR_OUTMODE0))
                regRdata <= outMode[groupIdx(regAddr, ADDR_OUTMODE0)];
            else if (inGroup(regAddr, ADDR_SKIP0))
                regRdata <= skip[groupIdx(regAddr, ADDR_SKIP0)];
            else if (inGroup(regAddr, ADDR_LATCH0)) begin
                // digital pins read the pad, analog pins read zero
                for (int b = 0; b < PORT_W; b++) begin
                    if (groupIdx(regAddr, ADDR_LATCH0) * PORT_W + b < PINS)
                        regRdata[b] <= padSync[groupIdx(regAddr,
                            ADDR_LATCH0) * PORT_W + b]
                            & inModeF[groupIdx(regAddr, ADDR_LATCH0)
                            * PORT_W + b];
                end
            end
        end
    end

    // which slots want a pin
    always_comb begin
        slotReq = '0;
        slotReq[SLOT_UART_TX]  = selFirst[SF_UART];
        slotReq[SLOT_UART_RX]  = selFirst[SF_UART];
        slotReq[SLOT_SPI_SCK]  = selFirst[SF_SPI];
        slotReq[SLOT_SPI_MISO] = selFirst[SF_SPI];
        slotReq[SLOT_SPI_MOSI] = selFirst[SF_SPI];
        slotReq[SLOT_SPI_NSS]  = selFirst[SF_SPI]
            && spiSlaveSelectMode != SPI_MODE_3WIRE;
        slotReq[SLOT_SMB0_SDA] = selFirst[SF_SMB0];
        slotReq[SLOT_SMB0_SCL] = selFirst[SF_SMB0];
        slotReq[SLOT_SMB1_SDA] = selFirst[SF_SMB1];
        slotReq[SLOT_SMB1_SCL] = selFirst[SF_SMB1];
        slotReq[SLOT_CP0]      = selFirst[SF_CP0];
        slotReq[SLOT_CP0A]     = selFirst[SF_CP0A];
        slotReq[SLOT_SYSCLK]   = selFirst[SF_SYSCK];
        slotReq[SLOT_CAPTURE_CHANNEL_ZERO_OUT]     = selSecond[SS_CEX_LSB +: 2] != 2'h0;
        slotReq[SLOT_CEX1]     = selSecond[SS_CEX_LSB +: 2] >= 2'h2;
        slotReq[SLOT_CEX2]     = selSecond[SS_CEX_LSB +: 2] == 2'h3;
        slotReq[SLOT_ECI]      = selSecond[SS_ECI];
        slotReq[SLOT_T0]       = selSecond[SS_T0];
        slotReq[SLOT_T1]       = selSecond[SS_T1];
    end

    // priority allocation, recomputed whenever any control bit moves
    always_comb begin
        logic [PINS-1:0] taken;
        logic            found;
        int              s;
        taken = '0;
        found = 1'b0;
        s = 0;
        nextOwned   = '0;
        nextSlotHas = '0;
        for (int p = 0; p < PINS; p++) nextPinSlot[p] = '0;
        for (int k = 0; k < SLOT_COUNT; k++) nextSlotPin[k] = '0;
        for (int p = 0; p < XBAR_PINS; p++)
            taken[p] = skipF[p];
        for (int p = XBAR_PINS; p < PINS; p++)
            taken[p] = 1'b1;
        if (xbarEn) begin
            if (slotReq[SLOT_UART_TX]) begin
                taken[UART_TX_PIN]       = 1'b1;
                taken[UART_RX_PIN]       = 1'b1;
                nextOwned[UART_TX_PIN]   = 1'b1;
                nextOwned[UART_RX_PIN]   = 1'b1;
                nextPinSlot[UART_TX_PIN] = SLOT_W'(SLOT_UART_TX);
                nextPinSlot[UART_RX_PIN] = SLOT_W'(SLOT_UART_RX);
                nextSlotHas[SLOT_UART_TX] = 1'b1;
                nextSlotHas[SLOT_UART_RX] = 1'b1;
                nextSlotPin[SLOT_UART_TX] = PIN_W'(UART_TX_PIN);
                nextSlotPin[SLOT_UART_RX] = PIN_W'(UART_RX_PIN);
            end
            // remaining slots in priority order take the lowest free pin
            for (int st = SLOT_SPI_SCK; st < SLOT_COUNT; st++) begin
                s = stepSlot(st, smbusPinSwap);
                found = 1'b0;
                if (slotReq[s] && (!isSmb(s) || nextSlotHas[s ^ 1]
                    || $countones(~taken[XBAR_PINS-1:0]) > 1)) begin
                    for (int p = 0; p < XBAR_PINS; p++) begin
                        if (!taken[p] && !found) begin
                            found          = 1'b1;
                            taken[p]       = 1'b1;
                            nextOwned[p]   = 1'b1;
                            nextPinSlot[p] = SLOT_W'(s);
                            nextSlotHas[s] = 1'b1;
                            nextSlotPin[s] = PIN_W'(p);
                        end
                    end
                end
            end
        end
    end

    // pad drive from the new routing
    always_comb begin
        logic val;
        logic drv;
        logic od;
        int   s;
        val = 1'b0;
        drv = 1'b0;
        od  = 1'b0;
        s   = 0;
        for (int i = 0; i < PINS; i++) begin
            s = int'(nextPinSlot[i]);
            if (nextOwned[i]) begin
                val = periphOut[s];
                drv = periphOe[s];
                od  = !outModeF[i] || isSmb(s);
            end else begin
                val = latchF[i];
                drv = 1'b1;
                od  = !outModeF[i];
            end
            next_smbPin[i] = nextOwned[i] && isSmb(s);
            next_padOe[i]  = xbarEn && inModeF[i] && drv
                && (!od || !val);
            next_padOut[i] = od ? 1'b0 : val;
            next_weakPullup[i] = inModeF[i] && od
                && !selSecond[SS_WEAK_PUD] && !next_padOe[i];
        end
    end

    // routing and pad state registered, applies next cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOwned <= '0;
            slotHas  <= '0;
            smbPin   <= '0;
            for (int k = 0; k < SLOT_COUNT; k++) slotPin[k] <= '0;
        end else begin
            pinOwned <= nextOwned;
            slotHas  <= nextSlotHas;
            smbPin   <= next_smbPin;
            for (int k = 0; k < SLOT_COUNT; k++)
                slotPin[k] <= nextSlotPin[k];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            padOut       <= '0;
            padOe        <= '0;
            weakPullup   <= '0;
            rxEnable     <= '0;
            strongPullup <= 2'h0;
        end else begin
            padOut       <= next_padOut;
            padOe        <= next_padOe;
            weakPullup   <= next_weakPullup;
            rxEnable     <= inModeF[PINS-1:0];
            strongPullup <= {2{selFirst[SF_STRONG_PU]}};
        end
    end

    // peripheral inputs read their routed pad, idle high otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            periphIn <= '1;
        end else begin
            for (int k = 0; k < SLOT_COUNT; k++)
                periphIn[k] <= slotHas[k] ? padSync[slotPin[k]] : 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence uartAsked;
        xbarEn && selFirst[SF_UART];
    endsequence
    sequence uartPlaced;
        slotHas[SLOT_UART_TX] && slotPin[SLOT_UART_TX] == PIN_W'(UART_TX_PIN)
        && slotPin[SLOT_UART_RX] == PIN_W'(UART_RX_PIN);
    endsequence

    uart_fixed_pins_a: assert property (uartAsked |=> uartPlaced)
        else $error("uart not on its fixed pins");

    smbus_pair_a: assert property (
        slotHas[SLOT_SMB0_SDA] == slotHas[SLOT_SMB0_SCL]
        && slotHas[SLOT_SMB1_SDA] == slotHas[SLOT_SMB1_SCL])
        else $error("smbus line allocated alone");

    xbar_off_idle_a: assert property (
        !xbarEn |=> padOe == '0 && pinOwned == '0)
        else $error("pin driven or routed while crossbar off");

    analog_pin_off_a: assert property (
        1'b1 |=> ((padOe | weakPullup | rxEnable)
                  & ~$past(inModeF[PINS-1:0])) == '0)
        else $error("analog pin has driver, pullup or receiver");

    strong_pullup_a: assert property (
        1'b1 |=> strongPullup == {2{$past(selFirst[SF_STRONG_PU])}})
        else $error("strong pullups do not follow select bit");

    skip_honored_a: assert property (
        1'b1 |=> (pinOwned[XBAR_PINS-1:0] & $past(skipF[XBAR_PINS-1:0])
                  & ~(XBAR_PINS'(1) << UART_TX_PIN)
                  & ~(XBAR_PINS'(1) << UART_RX_PIN)) == '0)
        else $error("crossbar claimed a skipped pin");

    nss_three_wire_a: assert property (
        spiSlaveSelectMode == SPI_MODE_3WIRE |=> !slotHas[SLOT_SPI_NSS])
        else $error("slave select routed in three-wire mode");

    smbus_open_drain_a: assert property (
        (smbPin & padOe & padOut) == '0)
        else $error("smbus pin driven high");

    smbus_swap_a: assert property (
        xbarEn && selFirst[SF_SMB0] && !smbusPinSwap[0]
        && !selFirst[SF_SMB1] |=> slotPin[SLOT_SMB0_SDA]
                                 < slotPin[SLOT_SMB0_SCL])
        else $error("smbus lines in wrong order");

    weak_pull_push_a: assert property (
        ##1 (weakPullup & $past(outModeF[PINS-1:0]) & ~smbPin) == '0)
        else $error("weak pullup on push-pull pin");
endmodule : pcxb_pin_mux

// ===== hdl/pcxb_pkg.sv
// constants of the priority crossbar pin multiplexer
package pcxb_pkg;
    // register map, byte offsets on the 8-bit register port
    localparam logic [7:0] ADDR_SEL_FIRST  = 8'he1;
    localparam logic [7:0] ADDR_SEL_SECOND = 8'he2;
    localparam logic [7:0] ADDR_INMODE0    = 8'hf1;
    localparam logic [7:0] ADDR_OUTMODE0   = 8'ha4;
    localparam logic [7:0] ADDR_SKIP0      = 8'hd4;
    localparam logic [7:0] ADDR_LATCH0     = 8'hc0;
    localparam int         PORT_COUNT      = 3;
    localparam int         PORT_W          = 8;

    // reset values
    localparam logic [7:0] SEL_FIRST_RST   = 8'h00;
    localparam logic [7:0] SEL_SECOND_RST  = 8'h00;
    localparam logic [7:0] INMODE_RST      = 8'hff;
    localparam logic [7:0] OUTMODE_RST     = 8'h00;
    localparam logic [7:0] SKIP_RST        = 8'h00;
    localparam logic [7:0] LATCH_RST       = 8'hff;

    // crossbar_select_first fields
    localparam int SF_STRONG_PU = 7;
    localparam int SF_SMB1      = 6;
    localparam int SF_CP0A      = 5;
    localparam int SF_CP0       = 4;
    localparam int SF_SYSCK     = 3;
    localparam int SF_SMB0      = 2;
    localparam int SF_SPI       = 1;
    localparam int SF_UART      = 0;

    // crossbar_select_second fields
    localparam int         SS_WEAK_PUD = 7;
    localparam int         SS_XBAR_EN  = 6;
    localparam int         SS_T1       = 5;
    localparam int         SS_T0       = 4;
    localparam int         SS_ECI      = 3;
    localparam int         SS_CEX_LSB  = 0;
    localparam logic [7:0] SS_RW_MASK  = 8'hfb;

    // fixed pins
    localparam int UART_TX_PIN  = 4;
    localparam int UART_RX_PIN  = 5;
    localparam int STRONG_PIN_A = 18;
    localparam int STRONG_PIN_B = 19;

    localparam logic [1:0] SPI_MODE_3WIRE = 2'h0;

    // peripheral signal slots in priority order
    localparam int SLOT_UART_TX  = 0;
    localparam int SLOT_UART_RX  = 1;
    localparam int SLOT_SPI_SCK  = 2;
    localparam int SLOT_SPI_MISO = 3;
    localparam int SLOT_SPI_MOSI = 4;
    localparam int SLOT_SPI_NSS  = 5;
    localparam int SLOT_SMB0_SDA = 6;
    localparam int SLOT_SMB0_SCL = 7;
    localparam int SLOT_SMB1_SDA = 8;
    localparam int SLOT_SMB1_SCL = 9;
    localparam int SLOT_CP0      = 10;
    localparam int SLOT_CP0A     = 11;
    localparam int SLOT_SYSCLK   = 12;
    localparam int SLOT_CAPTURE_CHANNEL_ZERO_OUT     = 13;
    localparam int SLOT_CEX1     = 14;
    localparam int SLOT_CEX2     = 15;
    localparam int SLOT_ECI      = 16;
    localparam int SLOT_T0       = 17;
    localparam int SLOT_T1       = 18;
    localparam int SLOT_COUNT    = 19;
    localparam int SLOT_W        = 5;
endpackage : pcxb_pkg

// ===== test/pcxb_pad_model.sv
// pad-side model: resolves each pad level from the block's drivers
`timescale 1ns/1ns
module pcxb_pad_model #(
    parameter int PINS = 21
) (
    // clock
    input  wire logic            clk,
    // from the block
    input  wire logic [PINS-1:0] padOut,
    input  wire logic [PINS-1:0] padOe,
    input  wire logic [PINS-1:0] weakPullup,
    input  wire logic [1:0]      strongPullup,
    // to the block
    output logic      [PINS-1:0] padIn
);
    logic [PINS-1:0] floatLvl = '0;
    logic [PINS-1:0] pulled;
    // undriven, unpulled pads toggle so no stale level survives
    always_ff @(posedge clk) begin
        floatLvl <= ~padIn;
    end
    always_comb begin
        pulled = weakPullup;
        pulled[19:18] = pulled[19:18] | strongPullup;
        for (int i = 0; i < PINS; i++) begin
            padIn[i] = padOe[i] ? padOut[i] : (pulled[i] | floatLvl[i]);
        end
    end
endmodule : pcxb_pad_model

// ===== test/pcxb_pin_mux_tb_top.sv
// self-checking bench for the crossbar pin multiplexer
`timescale 1ns/1ns
module pcxb_pin_mux_tb_top
    import pcxb_pkg::*;
;
    logic                  clk      = 1'b0;
    logic                  rst      = 1'b1;
    logic [7:0]            regAddr  = 8'h00;
    logic [7:0]            regWdata = 8'h00;
    logic                  regWrite = 1'b0;
    logic                  regRead  = 1'b0;
    logic [7:0]            regRdata;
    logic [SLOT_COUNT-1:0] periphOut = '0;
    logic [SLOT_COUNT-1:0] periphOe  = '1;
    logic [SLOT_COUNT-1:0] periphIn;
    logic [1:0]            smbusPinSwap = 2'h0;
    logic [1:0]            spiMode      = 2'h1;
    logic [20:0]           padIn;
    logic [20:0]           padOut;
    logic [20:0]           padOe;
    logic [20:0]           weakPullup;
    logic [20:0]           rxEnable;
    logic [1:0]            strongPullup;
    logic [7:0]            rdVal;
    int                    err_total  = 0;
    int                    n_compared = 0;

    pcxb_pin_mux dut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .periphOut(periphOut), .periphOe(periphOe),
        .periphIn(periphIn), .smbusPinSwap(smbusPinSwap),
        .spiSlaveSelectMode(spiMode), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .weakPullup(weakPullup), .rxEnable(rxEnable),
        .strongPullup(strongPullup));
    pcxb_pad_model pads (.clk(clk), .padOut(padOut), .padOe(padOe),
        .weakPullup(weakPullup), .strongPullup(strongPullup),
        .padIn(padIn));

    always #10 clk = ~clk;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 rdVal = regRdata;
    endtask : rd

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chkPins(input logic [20:0] got, input logic [20:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkPins

    // crossbar off, per port modes then skip, then selects, enable last
    task automatic setup(input logic [7:0] in0, input logic [7:0] skip0,
                         input logic [7:0] sel1, input logic [7:0] sel2);
        wr(ADDR_SEL_SECOND, 8'h00);
        for (int p = 0; p < PORT_COUNT; p++) begin
            wr(ADDR_INMODE0 + 8'(p), (p == 0) ? in0 : 8'hff);
            wr(ADDR_OUTMODE0 + 8'(p), 8'hff);
            wr(ADDR_SKIP0 + 8'(p), (p == 0) ? skip0 : 8'h00);
        end
        wr(ADDR_SEL_FIRST, sel1);
        wr(ADDR_SEL_SECOND, sel2);
        settle();
    endtask : setup

    // routed pins show peripheral 0, gpio pins the latch 1
    task automatic route(input logic [7:0] skip0, input logic [7:0] sel1,
                         input logic [7:0] sel2, input logic [19:0] mask);
        setup(8'hff, skip0, sel1, sel2);
        chkPins(padOut, {1'b1, ~mask});
        $display("routing test sel %h skip %h done", sel1, skip0);
    endtask : route

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #1000000;
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        settle();
        chkPins(rxEnable, 21'h1fffff);
        chkPins(padOe, 21'h0);
        rd(ADDR_SEL_FIRST);
        chk8(rdVal, 8'h00);
        wr(ADDR_SEL_FIRST, 8'h5a);
        wr(ADDR_SEL_SECOND, 8'hff);
        rd(ADDR_SEL_FIRST);
        chk8(rdVal, 8'h5a);
        rd(ADDR_SEL_SECOND);
        chk8(rdVal, 8'hfb);
        rd(8'h00);
        chk8(rdVal, 8'h00);
        $display("register test done");
        setup(8'hff, 8'h00, 8'h01, 8'h00);
        chkPins(padOe, 21'h0);
        $display("disabled test done");
        route(8'h00, 8'h01, 8'h40, 20'h00030);
        route(8'h01, 8'h03, 8'h40, 20'h0007e);
        @(posedge clk) spiMode <= SPI_MODE_3WIRE;
        route(8'h00, 8'h02, 8'h40, 20'h00007);
        route(8'h0c, 8'h05, 8'h41, 20'h00073);
        route(8'h00, 8'h7c, 8'h78, 20'h003ff);
        route(8'hff, 8'h84, 8'h40, 20'h00300);
        chkPins({19'h0, strongPullup}, 21'h3);
        @(posedge clk) periphOut <= 19'h40;
        setup(8'hff, 8'h00, 8'h04, 8'h40);
        chkPins({17'h0, weakPullup[1:0], padOe[1:0]}, 21'h6);
        @(posedge clk) smbusPinSwap <= 2'h1;
        settle();
        chkPins({17'h0, weakPullup[1:0], padOe[1:0]}, 21'h9);
        wr(ADDR_SEL_SECOND, 8'hc0);
        settle();
        chkPins({19'h0, weakPullup[1:0]}, 21'h0);
        $display("smbus test done");
        @(posedge clk) periphOut <= 19'h1;
        setup(8'hfe, 8'h01, 8'h01, 8'h40);
        chkPins({18'h0, rxEnable[0], weakPullup[0], padOe[0]}, 21'h0);
        chkPins(rxEnable, 21'h1ffffe);
        chkPins({20'h0, padOe[4]}, 21'h1);
        wr(ADDR_OUTMODE0, 8'h00);
        settle();
        chkPins({20'h0, padOe[4]}, 21'h0);
        rd(ADDR_LATCH0);
        chk8(rdVal, 8'hde);
        chkPins({18'h0, periphIn[2:0]}, 21'h5);
        wr(ADDR_LATCH0, 8'h7e);
        settle();
        rd(ADDR_LATCH0);
        chk8(rdVal, 8'h5e);
        $display("mode test done");
        end_of_test();
    end
endmodule : pcxb_pin_mux_tb_top
